// ### rtl/timer_output_compare_pulse_accum.sv
`timescale 1ns/1ps
// What this block does
// - Select bit 1 compare, 0 input.
// - Match drives pin: off, toggle, low, high.
// - Match sets flag; irq when enabled.
// - Force acts now, no flag, reads zero.
// - Channel 7 wins, copies masked data bits.
// - Mask bit forces output on compare channels, direction unchanged.
// - Channel 7 match clears counter when enabled.
// - Nonzero action code forces output on compare channels.
// - Port writes latched while compare owns pin.
// - 16-bit accumulator; mode event or gated.
// - Active edge counts, sets input flag.
// - Accumulator wrap sets overflow flag.
// - Event counting ignores run and background stop.
// - Gated mode counts divide-by-64 ticks.
// - Gated trailing edge sets input flag.
// - Timer disabled stops divide-by-64 tick.
// - Clear channel 7 action, mask for input.
// - Counter readable; writable only special mode.
// - First period after counter write varies.
// - Run enable stops or runs timer.
// - Wait and background stop bits halt.
// - Fast clear by access, else write one.
// - Polarity 1 rising/low, 0 falling/high.
module timer_output_compare_pulse_accum #(
    parameter int N_CH = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Chip modes
    input wire logic i_wait_mode,
    input wire logic i_bgnd_mode,
    input wire logic i_special_mode,
    // Timer port pins
    input wire logic [N_CH-1:0] i_port_in,
    output logic [N_CH-1:0] o_port_out,
    output logic [N_CH-1:0] o_port_oe,
    // Interrupt requests
    output logic [N_CH-1:0] o_chan_irq,
    output logic o_cnt_ovf_irq,
    output logic o_accum_in_irq,
    output logic o_accum_ovf_irq
);
    typedef struct packed {
        logic [N_CH-1:0] channel_direction_select;
        logic [N_CH-1:0] chan7_mask_bits;
        logic [N_CH-1:0] chan7_data_bits;
        logic [15:0] cnt;
        logic timer_run_enable;
        logic halt_in_wait;
        logic halt_in_background;
        logic fast_flag_clear;
        logic [2*N_CH-1:0] action;
        logic [N_CH-1:0] channel_irq_enable;
        logic [N_CH-1:0] channel_event_flag;
        logic counter_clear_on_chan7;
        logic cnt_ovf_ien;
        logic [2:0] psel;
        logic counter_overflow_flag;
        logic accum_en;
        logic accum_mode_bit;
        logic accum_polarity_bit;
        logic accum_overflow_irq_enable;
        logic accum_input_and_irq_enable;
        logic accum_overflow_flag;
        logic accum_input_flag;
        logic [15:0] accum_count_value;
        logic [N_CH-1:0] port_latch;
        logic [N_CH-1:0] timer_port_direction;
        logic [N_CH-1:0] oc_out;
        logic [N_CH-1:0][15:0] cmp;
        logic [tim_oc_pkg::PRESC_W-1:0] presc;
        logic [N_CH-1:0] sync1;
        logic [N_CH-1:0] sync2;
        logic acc_prev;
        logic [7:0] rdata;
    } state_s;

    state_s state_r;
    state_s state_nxt;
    logic [N_CH-1:0] owned;
    logic [N_CH-1:0] pin_val;

    always_comb
    begin
        for (int i = 0; i < N_CH; i++)
        begin
            owned[i] = state_r.channel_direction_select[i] &
                ((state_r.action[2*i +: 2] != tim_oc_pkg::ACT_OFF) | state_r.chan7_mask_bits[i]);
        end
        pin_val = (owned & state_r.oc_out) | (~owned & state_r.port_latch);
    end

    always_comb
    begin
        logic active;
        logic tick;
        logic div64;
        logic [tim_oc_pkg::PRESC_W-1:0] pmask;
        logic [N_CH-1:0] match;
        logic [N_CH-1:0] fire;
        logic [N_CH-1:0] set_flag;
        logic acc_in;
        logic edge_sel;
        logic gate;
        logic acc_inc;
        logic set_tof;
        logic set_aovf;
        logic set_ain;
        logic [7:0] base;
        active = 1'b0;
        tick = 1'b0;
        div64 = 1'b0;
        pmask = '0;
        match = '0;
        fire = '0;
        set_flag = '0;
        acc_in = 1'b0;
        edge_sel = 1'b0;
        gate = 1'b0;
        acc_inc = 1'b0;
        set_tof = 1'b0;
        set_aovf = 1'b0;
        set_ain = 1'b0;
        base = 8'h00;
        state_nxt = state_r;
        state_nxt.rdata = 8'h00;
        state_nxt.sync1 = i_port_in;
        state_nxt.sync2 = state_r.sync1;

        // Prescaler and counter tick
        active = state_r.timer_run_enable & ~(i_wait_mode & state_r.halt_in_wait)
            & ~(i_bgnd_mode & state_r.halt_in_background);
        unique case (state_r.psel)
            3'h0: pmask = 6'h00;
            3'h1: pmask = 6'h01;
            3'h2: pmask = 6'h03;
            3'h3: pmask = 6'h07;
            3'h4: pmask = 6'h0f;
            default: pmask = 6'h1f;
        endcase
        if (active)
        begin
            state_nxt.presc = state_r.presc + 6'h01;
        end
        tick = active & ((state_r.presc & pmask) == pmask);
        div64 = active & (state_r.presc == 6'h3f);

        // Compare matches and forced compares
        for (int i = 0; i < N_CH; i++)
        begin
            match[i] = tick & state_r.channel_direction_select[i] & (state_r.cnt == state_r.cmp[i]);
            fire[i] = match[i] | (i_wr & (i_addr == tim_oc_pkg::OFS_FORCE) & i_wdata[i]
                & state_r.channel_direction_select[i]);
        end
        set_flag = match;
        for (int i = 0; i < N_CH; i++)
        begin
            if (fire[N_CH-1] & state_r.chan7_mask_bits[i])
            begin
                state_nxt.oc_out[i] = state_r.chan7_data_bits[i];
            end
            else if (fire[i])
            begin
                unique case (state_r.action[2*i +: 2])
                    tim_oc_pkg::ACT_TOGGLE: state_nxt.oc_out[i] = ~state_r.oc_out[i];
                    tim_oc_pkg::ACT_LOW: state_nxt.oc_out[i] = 1'b0;
                    tim_oc_pkg::ACT_HIGH: state_nxt.oc_out[i] = 1'b1;
                    tim_oc_pkg::ACT_OFF: state_nxt.oc_out[i] = state_r.oc_out[i];
                endcase
            end
        end

        // Free-running counter
        if (tick)
        begin
            if (match[N_CH-1] & state_r.counter_clear_on_chan7)
            begin
                state_nxt.cnt = 16'h0000;
            end
            else
            begin
                state_nxt.cnt = state_r.cnt + 16'h0001;
                set_tof = (state_r.cnt == 16'hffff);
            end
        end

        // Pulse accumulator
        acc_in = state_r.sync2[tim_oc_pkg::ACC_PIN];
        edge_sel = state_r.accum_polarity_bit ? (acc_in & ~state_r.acc_prev)
            : (~acc_in & state_r.acc_prev);
        gate = state_r.accum_polarity_bit ? ~acc_in : acc_in;
        state_nxt.acc_prev = acc_in;
        if (state_r.accum_en & ~(i_wait_mode & state_r.halt_in_wait))
        begin
            acc_inc = state_r.accum_mode_bit ? (gate & div64) : edge_sel;
            set_ain = edge_sel;
        end
        if (acc_inc)
        begin
            state_nxt.accum_count_value = state_r.accum_count_value + 16'h0001;
            set_aovf = (state_r.accum_count_value == 16'hffff);
        end

        // Register writes
        if (i_wr)
        begin
            unique case (i_addr)
                tim_oc_pkg::OFS_DIR_SEL: state_nxt.channel_direction_select = i_wdata;
                tim_oc_pkg::OFS_C7_MASK: state_nxt.chan7_mask_bits = i_wdata;
                tim_oc_pkg::OFS_C7_DATA: state_nxt.chan7_data_bits = i_wdata;
                tim_oc_pkg::OFS_CNT_HI:
                begin
                    if (i_special_mode)
                    begin
                        state_nxt.cnt[15:8] = i_wdata;
                    end
                end
                tim_oc_pkg::OFS_CNT_LO:
                begin
                    if (i_special_mode)
                    begin
                        state_nxt.cnt[7:0] = i_wdata;
                    end
                end
                tim_oc_pkg::OFS_SYS_CTRL:
                begin
                    state_nxt.timer_run_enable = i_wdata[tim_oc_pkg::SYS_RUN];
                    state_nxt.halt_in_wait = i_wdata[tim_oc_pkg::SYS_HWAIT];
                    state_nxt.halt_in_background = i_wdata[tim_oc_pkg::SYS_HBGND];
                    state_nxt.fast_flag_clear = i_wdata[tim_oc_pkg::SYS_FAST];
                end
                tim_oc_pkg::OFS_ACT_UP: state_nxt.action[15:8] = i_wdata;
                tim_oc_pkg::OFS_ACT_LO: state_nxt.action[7:0] = i_wdata;
                tim_oc_pkg::OFS_CH_IEN: state_nxt.channel_irq_enable = i_wdata;
                tim_oc_pkg::OFS_CH_FLAG: state_nxt.channel_event_flag = state_r.channel_event_flag & ~i_wdata;
                tim_oc_pkg::OFS_CNT_CTRL:
                begin
                    state_nxt.counter_clear_on_chan7 = i_wdata[tim_oc_pkg::CC_CLR7];
                    state_nxt.cnt_ovf_ien = i_wdata[tim_oc_pkg::CC_TOF_IEN];
                    state_nxt.psel = i_wdata[tim_oc_pkg::CC_PSEL +: 3];
                end
                tim_oc_pkg::OFS_CNT_FLAG:
                begin
                    if (i_wdata[tim_oc_pkg::CF_TOF])
                    begin
                        state_nxt.counter_overflow_flag = 1'b0;
                    end
                end
                tim_oc_pkg::OFS_ACC_CTRL:
                begin
                    state_nxt.accum_en = i_wdata[tim_oc_pkg::AC_EN];
                    state_nxt.accum_mode_bit = i_wdata[tim_oc_pkg::AC_MODE];
                    state_nxt.accum_polarity_bit = i_wdata[tim_oc_pkg::AC_POL];
                    state_nxt.accum_overflow_irq_enable = i_wdata[tim_oc_pkg::AC_OVF_IEN];
                    state_nxt.accum_input_and_irq_enable = i_wdata[tim_oc_pkg::AC_IN_IEN];
                end
                tim_oc_pkg::OFS_ACC_FLAG:
                begin
                    if (i_wdata[tim_oc_pkg::AF_OVF])
                    begin
                        state_nxt.accum_overflow_flag = 1'b0;
                    end
                    if (i_wdata[tim_oc_pkg::AF_IN])
                    begin
                        state_nxt.accum_input_flag = 1'b0;
                    end
                end
                tim_oc_pkg::OFS_ACC_HI: state_nxt.accum_count_value[15:8] = i_wdata;
                tim_oc_pkg::OFS_ACC_LO: state_nxt.accum_count_value[7:0] = i_wdata;
                tim_oc_pkg::OFS_PORT_DATA: state_nxt.port_latch = i_wdata;
                tim_oc_pkg::OFS_PORT_DIR: state_nxt.timer_port_direction = i_wdata;
                default: state_nxt.rdata = 8'h00;
            endcase
            for (int i = 0; i < N_CH; i++)
            begin
                base = 8'(tim_oc_pkg::OFS_CMP_BASE + 2 * i);
                if (i_addr == base)
                begin
                    state_nxt.cmp[i][15:8] = i_wdata;
                end
                if (i_addr == 8'(base + 8'h01))
                begin
                    state_nxt.cmp[i][7:0] = i_wdata;
                end
                if (state_r.fast_flag_clear & state_r.channel_direction_select[i]
                    & ((i_addr == base) | (i_addr == 8'(base + 8'h01))))
                begin
                    state_nxt.channel_event_flag[i] = 1'b0;
                end
            end
        end

        // Register reads
        if (i_rd)
        begin
            unique case (i_addr)
                tim_oc_pkg::OFS_DIR_SEL: state_nxt.rdata = state_r.channel_direction_select;
                tim_oc_pkg::OFS_FORCE: state_nxt.rdata = 8'h00;
                tim_oc_pkg::OFS_C7_MASK: state_nxt.rdata = state_r.chan7_mask_bits;
                tim_oc_pkg::OFS_C7_DATA: state_nxt.rdata = state_r.chan7_data_bits;
                tim_oc_pkg::OFS_CNT_HI: state_nxt.rdata = state_r.cnt[15:8];
                tim_oc_pkg::OFS_CNT_LO: state_nxt.rdata = state_r.cnt[7:0];
                tim_oc_pkg::OFS_SYS_CTRL: state_nxt.rdata = {state_r.timer_run_enable, state_r.halt_in_wait,
                    state_r.halt_in_background, state_r.fast_flag_clear, 4'h0};
                tim_oc_pkg::OFS_ACT_UP: state_nxt.rdata = state_r.action[15:8];
                tim_oc_pkg::OFS_ACT_LO: state_nxt.rdata = state_r.action[7:0];
                tim_oc_pkg::OFS_CH_IEN: state_nxt.rdata = state_r.channel_irq_enable;
                tim_oc_pkg::OFS_CH_FLAG: state_nxt.rdata = state_r.channel_event_flag;
                tim_oc_pkg::OFS_CNT_CTRL: state_nxt.rdata = {state_r.counter_clear_on_chan7,
                    state_r.cnt_ovf_ien, 3'h0, state_r.psel};
                tim_oc_pkg::OFS_CNT_FLAG: state_nxt.rdata = {state_r.counter_overflow_flag, 7'h00};
                tim_oc_pkg::OFS_ACC_CTRL: state_nxt.rdata = {1'b0, state_r.accum_en, state_r.accum_mode_bit,
                    state_r.accum_polarity_bit, 2'h0, state_r.accum_overflow_irq_enable,
                    state_r.accum_input_and_irq_enable};
                tim_oc_pkg::OFS_ACC_FLAG: state_nxt.rdata = {6'h00, state_r.accum_overflow_flag,
                    state_r.accum_input_flag};
                tim_oc_pkg::OFS_ACC_HI: state_nxt.rdata = state_r.accum_count_value[15:8];
                tim_oc_pkg::OFS_ACC_LO: state_nxt.rdata = state_r.accum_count_value[7:0];
                tim_oc_pkg::OFS_PORT_DATA: state_nxt.rdata = (o_port_oe & pin_val) | (~o_port_oe & state_r.sync2);
                tim_oc_pkg::OFS_PORT_DIR: state_nxt.rdata = state_r.timer_port_direction;
                default: state_nxt.rdata = 8'h00;
            endcase
            for (int i = 0; i < N_CH; i++)
            begin
                base = 8'(tim_oc_pkg::OFS_CMP_BASE + 2 * i);
                if (i_addr == base)
                begin
                    state_nxt.rdata = state_r.cmp[i][15:8];
                end
                if (i_addr == 8'(base + 8'h01))
                begin
                    state_nxt.rdata = state_r.cmp[i][7:0];
                end
                if (state_r.fast_flag_clear & ~state_r.channel_direction_select[i]
                    & ((i_addr == base) | (i_addr == 8'(base + 8'h01))))
                begin
                    state_nxt.channel_event_flag[i] = 1'b0;
                end
            end
        end

        // Fast clear on counter and accumulator access
        if ((i_rd | i_wr) & state_r.fast_flag_clear)
        begin
            if ((i_addr == tim_oc_pkg::OFS_CNT_HI) | (i_addr == tim_oc_pkg::OFS_CNT_LO))
            begin
                state_nxt.counter_overflow_flag = 1'b0;
            end
            if ((i_addr == tim_oc_pkg::OFS_ACC_HI) | (i_addr == tim_oc_pkg::OFS_ACC_LO))
            begin
                state_nxt.accum_overflow_flag = 1'b0;
                state_nxt.accum_input_flag = 1'b0;
            end
        end

        // Hardware sets win over clears
        state_nxt.channel_event_flag = state_nxt.channel_event_flag | set_flag;
        if (set_tof)
        begin
            state_nxt.counter_overflow_flag = 1'b1;
        end
        if (set_aovf)
        begin
            state_nxt.accum_overflow_flag = 1'b1;
        end
        if (set_ain)
        begin
            state_nxt.accum_input_flag = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign o_rdata = state_r.rdata;
    assign o_port_oe = owned | state_r.timer_port_direction;
    assign o_port_out = pin_val;
    assign o_chan_irq = state_r.channel_event_flag & state_r.channel_irq_enable;
    assign o_cnt_ovf_irq = state_r.counter_overflow_flag & state_r.cnt_ovf_ien;
    assign o_accum_in_irq = state_r.accum_input_flag & state_r.accum_input_and_irq_enable;
    assign o_accum_ovf_irq = state_r.accum_overflow_flag & state_r.accum_overflow_irq_enable;
endmodule

// ### rtl/tim_oc_pkg.sv
package tim_oc_pkg;
    // Register offsets (byte addresses on the plain port)
    localparam logic [7:0] OFS_DIR_SEL = 8'h00;
    localparam logic [7:0] OFS_FORCE = 8'h01;
    localparam logic [7:0] OFS_C7_MASK = 8'h02;
    localparam logic [7:0] OFS_C7_DATA = 8'h03;
    localparam logic [7:0] OFS_CNT_HI = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h05;
    localparam logic [7:0] OFS_SYS_CTRL = 8'h06;
    localparam logic [7:0] OFS_ACT_UP = 8'h08;
    localparam logic [7:0] OFS_ACT_LO = 8'h09;
    localparam logic [7:0] OFS_CH_IEN = 8'h0a;
    localparam logic [7:0] OFS_CH_FLAG = 8'h0b;
    localparam logic [7:0] OFS_CNT_CTRL = 8'h0c;
    localparam logic [7:0] OFS_CNT_FLAG = 8'h0d;
    localparam logic [7:0] OFS_ACC_CTRL = 8'h0e;
    localparam logic [7:0] OFS_ACC_FLAG = 8'h0f;
    localparam logic [7:0] OFS_ACC_HI = 8'h10;
    localparam logic [7:0] OFS_ACC_LO = 8'h11;
    localparam logic [7:0] OFS_PORT_DATA = 8'h12;
    localparam logic [7:0] OFS_PORT_DIR = 8'h13;
    localparam logic [7:0] OFS_CMP_BASE = 8'h14;
    // Field positions
    localparam int SYS_RUN = 7;
    localparam int SYS_HWAIT = 6;
    localparam int SYS_HBGND = 5;
    localparam int SYS_FAST = 4;
    localparam int CC_CLR7 = 7;
    localparam int CC_TOF_IEN = 6;
    localparam int CC_PSEL = 0;
    localparam int CF_TOF = 7;
    localparam int AC_EN = 6;
    localparam int AC_MODE = 5;
    localparam int AC_POL = 4;
    localparam int AC_OVF_IEN = 1;
    localparam int AC_IN_IEN = 0;
    localparam int AF_OVF = 1;
    localparam int AF_IN = 0;
    localparam int ACC_PIN = 7;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // Prescaler width: six stages give the divide-by-64 tick
    localparam int PRESC_W = 6;
    // Action codes
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_LOW = 2'h2;
    localparam logic [1:0] ACT_HIGH = 2'h3;
endpackage

// ### tb/pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
    // Clock
    input wire logic i_sys_clk,
    // Timer pin drive
    input wire logic [7:0] i_port_out,
    input wire logic [7:0] i_port_oe,
    // Resolved pin levels
    output logic [7:0] o_pin
);
    logic [7:0] ext_r = 8'h00;
    // Timer drives where enabled
    assign o_pin = (i_port_oe & i_port_out) | (~i_port_oe & ext_r);
    // Pulses on the accumulator pin
    task automatic pulses(input int n, input int w);
        repeat (n)
        begin
            @(posedge i_sys_clk);
            ext_r[7] <= 1'b1;
            repeat (w) @(posedge i_sys_clk);
            ext_r[7] <= 1'b0;
            repeat (w - 1) @(posedge i_sys_clk);
        end
    endtask
endmodule

// ### tb/timer_oc_properties.sv
`timescale 1ns/1ps
module timer_oc_checker #(
    parameter int N_CH = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Pins and requests
    input wire logic [N_CH-1:0] o_port_out,
    input wire logic [N_CH-1:0] o_port_oe,
    input wire logic [N_CH-1:0] o_chan_irq,
    input wire logic o_accum_in_irq,
    input wire logic o_accum_ovf_irq
);
    logic [7:0] dir_r, mask_r, ien_r, acc_r, act_on;
    logic [15:0] act_r;
    // Shadow of written control registers
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            dir_r <= 8'h00;
            mask_r <= 8'h00;
            ien_r <= 8'h00;
            acc_r <= 8'h00;
            act_r <= 16'h0000;
        end
        else if (i_wr)
        begin
            if (i_addr == tim_oc_pkg::OFS_DIR_SEL) dir_r <= i_wdata;
            if (i_addr == tim_oc_pkg::OFS_C7_MASK) mask_r <= i_wdata;
            if (i_addr == tim_oc_pkg::OFS_CH_IEN) ien_r <= i_wdata;
            if (i_addr == tim_oc_pkg::OFS_ACC_CTRL) acc_r <= i_wdata;
            if (i_addr == tim_oc_pkg::OFS_ACT_LO) act_r[7:0] <= i_wdata;
            if (i_addr == tim_oc_pkg::OFS_ACT_UP) act_r[15:8] <= i_wdata;
        end
    end
    always_comb
    begin
        for (int i = 0; i < 8; i++) act_on[i] = |act_r[2*i +: 2];
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    property p_rd_zero; i_rd && (i_addr == tim_oc_pkg::OFS_FORCE || i_addr == 8'h07) |=> o_rdata == 8'h00; endproperty
    property p_force_level;
        i_wr && i_addr == tim_oc_pkg::OFS_FORCE && i_wdata[1] && !i_wdata[7] && dir_r[1] && act_r[3]
        |=> o_port_out[1] == $past(act_r[2]);
    endproperty
    property p_force_toggle;
        i_wr && i_addr == tim_oc_pkg::OFS_FORCE && i_wdata[2] && !i_wdata[7] && dir_r[2] && act_r[5:4] == 2'h1
        |=> o_port_out[2] != $past(o_port_out[2]);
    endproperty
    property p_chan_irq; (o_chan_irq & ~ien_r) == 8'h00; endproperty
    property p_in_irq; o_accum_in_irq |-> acc_r[tim_oc_pkg::AC_IN_IEN]; endproperty
    property p_ovf_irq; o_accum_ovf_irq |-> acc_r[tim_oc_pkg::AC_OVF_IEN]; endproperty
    property p_oe_action; (dir_r & act_on & ~o_port_oe) == 8'h00; endproperty
    property p_oe_mask; (dir_r & mask_r & ~o_port_oe) == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    a_rd_zero: assert property (p_rd_zero) else $error("force or unmapped read not zero");
    a_force_level: assert property (p_force_level) else $error("forced level wrong");
    a_force_toggle: assert property (p_force_toggle) else $error("forced toggle missing");
    a_chan_irq: assert property (p_chan_irq) else $error("channel request while disabled");
    a_in_irq: assert property (p_in_irq) else $error("input request while disabled");
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request while disabled");
    a_oe_action: assert property (p_oe_action) else $error("compare pin not output");
    a_oe_mask: assert property (p_oe_mask) else $error("masked pin not output");
    c_force: cover property (i_wr && i_addr == tim_oc_pkg::OFS_FORCE);
    c_ovf: cover property (o_accum_ovf_irq);
    c_chan: cover property ($rose(o_chan_irq[0]));
endmodule
bind timer_output_compare_pulse_accum timer_oc_checker #(.N_CH(N_CH)) timer_oc_checker_inst (
    .i_sys_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_port_out, .o_port_oe, .o_chan_irq, .o_accum_in_irq, .o_accum_ovf_irq
);

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wr = 1'b0, rd = 1'b0, bgnd_m = 1'b0, spec_m = 1'b0, wait_m = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic [7:0] rdata, port_in, port_out, port_oe, chan_irq;
    logic ain_irq, aovf_irq, tovf_irq;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    timer_output_compare_pulse_accum timer_output_compare_pulse_accum_inst (
        .i_sys_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_wait_mode(wait_m), .i_bgnd_mode(bgnd_m), .i_special_mode(spec_m),
        .i_port_in(port_in), .o_port_out(port_out), .o_port_oe(port_oe), .o_chan_irq(chan_irq),
        .o_cnt_ovf_irq(tovf_irq), .o_accum_in_irq(ain_irq), .o_accum_ovf_irq(aovf_irq)
    );
    pin_partner pin_partner_inst (.i_sys_clk(clk), .i_port_out(port_out), .i_port_oe(port_oe), .o_pin(port_in));
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        num_checks++;
        if (got !== e)
        begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        // Reset values, then direction select write
        rd_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h00);
        rd_reg(8'h07, 8'h00);
        wr_reg(tim_oc_pkg::OFS_DIR_SEL, 8'hff);
        rd_reg(tim_oc_pkg::OFS_DIR_SEL, 8'hff);
        // Forced actions
        wr_reg(tim_oc_pkg::OFS_ACT_LO, 8'h1b);
        wr_reg(tim_oc_pkg::OFS_FORCE, 8'h0f);
        rd_reg(tim_oc_pkg::OFS_FORCE, 8'h00);
        chk(port_out & 8'h07, 8'h05);
        chk(port_oe & 8'h0f, 8'h07);
        rd_reg(tim_oc_pkg::OFS_CH_FLAG, 8'h00);
        // Port latch
        wr_reg(tim_oc_pkg::OFS_PORT_DATA, 8'hff);
        wr_reg(tim_oc_pkg::OFS_PORT_DIR, 8'h02);
        chk(port_out & 8'h02, 8'h00);
        wr_reg(tim_oc_pkg::OFS_ACT_LO, 8'h13);
        chk(port_out & port_oe & 8'h02, 8'h02);
        // Counter match
        wr_reg(tim_oc_pkg::OFS_ACT_LO, 8'h12);
        wr_reg(tim_oc_pkg::OFS_CMP_BASE + 8'h01, 8'h10);
        wr_reg(tim_oc_pkg::OFS_CH_IEN, 8'h01);
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h80);
        repeat (30) @(posedge clk);
        @(negedge clk);
        chk(port_out & 8'h01, 8'h00);
        chk(chan_irq, 8'h01);
        wr_reg(tim_oc_pkg::OFS_CH_FLAG, 8'h0f);
        chk(chan_irq, 8'h00);
        // Counter writes
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h00);
        wr_reg(tim_oc_pkg::OFS_CNT_HI, 8'h12);
        rd_reg(tim_oc_pkg::OFS_CNT_HI, 8'h00);
        @(posedge clk);
        spec_m <= 1'b1;
        wr_reg(tim_oc_pkg::OFS_CNT_HI, 8'h12);
        wr_reg(tim_oc_pkg::OFS_CNT_LO, 8'h34);
        rd_reg(tim_oc_pkg::OFS_CNT_LO, 8'h34);
        // Channel 7 masked data, counter clear, overflow and fast clear
        wr_reg(tim_oc_pkg::OFS_C7_MASK, 8'h30);
        wr_reg(tim_oc_pkg::OFS_C7_DATA, 8'h20);
        wr_reg(tim_oc_pkg::OFS_CMP_BASE + 8'h0e, 8'h12);
        wr_reg(tim_oc_pkg::OFS_CMP_BASE + 8'h0f, 8'h38);
        wr_reg(tim_oc_pkg::OFS_CNT_CTRL, 8'hc0);
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h80);
        repeat (20) @(posedge clk);
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h00);
        chk(port_out & 8'h30, 8'h20);
        chk(port_oe & 8'h30, 8'h30);
        rd_reg(tim_oc_pkg::OFS_CNT_HI, 8'h00);
        rd_reg(tim_oc_pkg::OFS_PORT_DIR, 8'h02);
        wr_reg(tim_oc_pkg::OFS_CNT_HI, 8'hff);
        wr_reg(tim_oc_pkg::OFS_CNT_LO, 8'hff);
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h90);
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h10);
        chk({7'h00, tovf_irq}, 8'h01);
        rd_reg(tim_oc_pkg::OFS_CNT_HI, 8'h00);
        chk({7'h00, tovf_irq}, 8'h00);
        // Event counting
        @(posedge clk);
        bgnd_m <= 1'b1;
        wait_m <= 1'b1;
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h20);
        wr_reg(tim_oc_pkg::OFS_ACC_CTRL, 8'h51);
        pin_partner_inst.pulses(5, 4);
        rd_reg(tim_oc_pkg::OFS_ACC_LO, 8'h05);
        chk({7'h00, ain_irq}, 8'h01);
        // Accumulator wrap
        wr_reg(tim_oc_pkg::OFS_ACC_HI, 8'hff);
        wr_reg(tim_oc_pkg::OFS_ACC_LO, 8'hff);
        wr_reg(tim_oc_pkg::OFS_ACC_CTRL, 8'h53);
        pin_partner_inst.pulses(1, 4);
        rd_reg(tim_oc_pkg::OFS_ACC_HI, 8'h00);
        chk({7'h00, aovf_irq}, 8'h01);
        // Gated accumulation, timer stop and wait halt
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h80);
        wr_reg(tim_oc_pkg::OFS_ACC_LO, 8'h00);
        wr_reg(tim_oc_pkg::OFS_ACC_FLAG, 8'h03);
        wr_reg(tim_oc_pkg::OFS_ACC_CTRL, 8'h61);
        chk({7'h00, ain_irq}, 8'h00);
        pin_partner_inst.pulses(1, 192);
        rd_reg(tim_oc_pkg::OFS_ACC_LO, 8'h03);
        chk({7'h00, ain_irq}, 8'h01);
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h00);
        pin_partner_inst.pulses(1, 192);
        rd_reg(tim_oc_pkg::OFS_ACC_LO, 8'h03);
        wr_reg(tim_oc_pkg::OFS_SYS_CTRL, 8'h40);
        wr_reg(tim_oc_pkg::OFS_ACC_CTRL, 8'h41);
        pin_partner_inst.pulses(1, 4);
        rd_reg(tim_oc_pkg::OFS_ACC_LO, 8'h03);
        print_verdict();
    end
endmodule
